// ---- rtl/pit_consts.vh ----
/*
 Constants for the programmable interval timer: APB register offsets,
 field positions, reset values and clock-rate figures.
 Assumes a 25 MHz system clock.
*/
`ifndef PIT_CONSTS_VH
`define PIT_CONSTS_VH
`define SYS_CLK_HZ 25000000
`define REF_FAST_HZ 2460000
`define REF_SLOW_HZ 153600
`define REF_FAST_DIV ((`SYS_CLK_HZ + `REF_FAST_HZ / 2) / `REF_FAST_HZ)
`define REF_SLOW_DIV ((`SYS_CLK_HZ + `REF_SLOW_HZ / 2) / `REF_SLOW_HZ)
`define OFF_CTRL0 12'h000
`define OFF_CTRL1 12'h004
`define OFF_CTRL2 12'h008
`define OFF_LOAD0 12'h010
`define OFF_LOAD1 12'h014
`define OFF_LOAD2 12'h018
`define OFF_COUNT0 12'h020
`define OFF_COUNT1 12'h024
`define OFF_COUNT2 12'h028
`define OFF_REFSEL 12'h030
`define OFF_SWTRIG 12'h034
`define OFF_STATUS 12'h038
`define OFF_MASK 12'h03c
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 2
`define CTRL_BCD_BIT 3
`define CTRL_EXT_BIT 4
`define CTRL_RESET 5'h00
`define MODE_TC_IRQ 3'h0
`define MODE_ONE_SHOT 3'h1
`define MODE_RATE 3'h2
`define MODE_SQUARE 3'h3
`define MODE_SW_STROBE 3'h4
`define MODE_HW_STROBE 3'h5
`define MODE_EVENT 3'h6
`define LOAD_RESET 16'h0000
`endif

// ---- rtl/pit_counter.v ----
/*
 One 16-bit down-counter with seven output functions.
 Assumes tick and gate_rise are one-cycle pulses already
 synchronised to clk_sys.
*/
`timescale 1ns/10ps
`include "pit_consts.vh"
module pit_counter (
  input wire clk_sys,
  input wire rst,
  input wire [2:0] mode,
  input wire bcd,
  input wire [15:0] load_val,
  input wire load_stb,
  input wire sw_trig,
  input wire tick,
  input wire gate_lvl,
  input wire gate_rise,
  output reg [15:0] count_reg,
  output reg out_reg,
  output reg tc_pulse
);
  reg armed_reg;
  reg half_reg;
  reg [15:0] dec;
  reg borrow;
  wire gate_ok;
  wire hw_start;
  wire at_zero;
  integer i;
  assign at_zero = (count_reg == 16'h0000);
  assign gate_ok = (mode == `MODE_EVENT || mode == `MODE_TC_IRQ ||
                    mode == `MODE_RATE || mode == `MODE_SQUARE) ?
                   gate_lvl : 1'b1;
  assign hw_start = (mode == `MODE_ONE_SHOT) ? (gate_rise | sw_trig) :
                    (mode == `MODE_HW_STROBE) ? gate_rise : 1'b0;
  // BCD decrement walks nibbles so 0000 wraps to 9999
  always @* begin
    dec = count_reg - 16'h0001;
    borrow = 1'b1;
    if (bcd) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (!borrow) begin
          dec[i*4 +: 4] = count_reg[i*4 +: 4];
        end else if (count_reg[i*4 +: 4] == 4'h0) begin
          dec[i*4 +: 4] = 4'h9;
        end else begin
          dec[i*4 +: 4] = count_reg[i*4 +: 4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
  end
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_reg <= 16'h0000;
      out_reg <= 1'b1;
      tc_pulse <= 1'b0;
      armed_reg <= 1'b0;
      half_reg <= 1'b0;
    end else begin
      tc_pulse <= 1'b0;
      if (load_stb) begin
        count_reg <= load_val;
        armed_reg <= (mode != `MODE_ONE_SHOT && mode != `MODE_HW_STROBE);
        out_reg <= (mode != `MODE_TC_IRQ);
        half_reg <= 1'b0;
      end else if (hw_start) begin
        count_reg <= load_val; // see RL7 RL11
        armed_reg <= 1'b1;
        out_reg <= (mode != `MODE_ONE_SHOT); // see RL7
      end else if (tick && armed_reg && gate_ok) begin
        count_reg <= dec; // see RL1 RL16
        if (dec == 16'h0000) begin
          tc_pulse <= 1'b1; // see RL6 RL12
          case (mode)
            `MODE_TC_IRQ: begin
              out_reg <= 1'b1;
              armed_reg <= 1'b0;
            end
            `MODE_ONE_SHOT: begin
              out_reg <= 1'b1; // see RL7
              armed_reg <= 1'b0;
            end
            `MODE_RATE: begin
              out_reg <= 1'b0; // see RL8
              count_reg <= load_val;
            end
            `MODE_SQUARE: begin
              count_reg <= load_val;
            end
            `MODE_SW_STROBE, `MODE_HW_STROBE: begin
              out_reg <= 1'b0; // see RL10 RL11
              armed_reg <= 1'b0;
            end
            default: begin
              armed_reg <= armed_reg;
            end
          endcase
        end else begin
          if (mode == `MODE_RATE) begin
            out_reg <= 1'b1;
          end
          if (mode == `MODE_SQUARE) begin
            // Low half begins once the count passes N/2
            out_reg <= (dec >= {1'b0, load_val[15:1]}); // see RL9
          end
        end
      end else if (tick && !armed_reg &&
                   (mode == `MODE_SW_STROBE || mode == `MODE_HW_STROBE)) begin
        out_reg <= 1'b1;
      end
      if (at_zero && half_reg) begin
        half_reg <= 1'b0;
      end
    end
  end
endmodule // pit_counter

// ---- rtl/pit_top.v ----
/*
 Three-counter programmable interval timer behind an APB slave.
 Assumes external gate and event pins are asynchronous to clk_sys
 and are synchronised here before use.
*/
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/10ps
`include "pit_consts.vh"
// Functional notes
// RL1: Each counter counts in binary or BCD as its own control bit selects.
// RL2: Counter two drives the serial baud clock output.
// RL3: Counters zero and one have their own outputs, interrupt and gates.
// RL4: Each counter has its own mode field, written without touching others.
// RL5: The live count of every counter reads back while it keeps counting.
// RL6: Interrupt-on-terminal-count raises a request when the count ends.
// RL7: One-shot drops low on a trigger edge or software command, retriggers.
// RL8: Rate generator pulses low one input clock every N input clocks.
// RL9: Square wave is high for the first half of N and low for the rest.
// RL10: Software strobe goes low one clock N counts after a load.
// RL11: Hardware strobe goes low one clock N counts after a gate rise.
// RL12: Event counter counts an external signal and can interrupt after N.
// RL13: There are three independent sixteen-bit counters.
// RL14: The count reference is selectable between 2.46 MHz and 153.6 kHz; the code divides to 2.5 MHz and about 153.4 kHz.
// RL15: Software sets the baud divisor by writing counter two's load word.
// RL16: Counters decrement once per active tick while gated; zero is terminal.
module pit_top (
  input wire clk_sys,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [1:0] gate_pin,
  input wire [1:0] event_pin,
  output reg [1:0] timer_out,
  output reg baud_clk,
  output reg irq
);
  reg [4:0] ctrl_reg [0:2];
  reg [15:0] load_reg [0:2];
  reg [2:0] load_stb_reg;
  reg [2:0] sw_trig_reg;
  reg refsel_reg;
  reg [2:0] status_reg;
  reg [2:0] mask_reg;
  localparam [31:0] FAST_TOP = `REF_FAST_DIV - 1;
  localparam [31:0] SLOW_TOP = `REF_SLOW_DIV - 1;
  reg [7:0] div_reg;
  reg tick_reg;
  reg [1:0] gate_s1_reg;
  reg [1:0] gate_s2_reg;
  reg [1:0] gate_d_reg;
  reg [1:0] ev_s1_reg;
  reg [1:0] ev_s2_reg;
  reg [1:0] ev_d_reg;
  wire [15:0] count_w [0:2];
  wire [2:0] out_w;
  wire [2:0] tc_w;
  wire [2:0] gate_lvl_w;
  wire [2:0] gate_rise_w;
  wire [2:0] tick_w;
  wire wr_en;
  wire rd_en;
  wire [7:0] div_top;
  reg [31:0] rd_mux;
  reg rd_hit;
  reg [2:0] status_next;
  integer k;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  // Rounded divisors: 10 cycles gives 2.5 MHz, 163 gives about 153.4 kHz
  assign div_top = refsel_reg ? SLOW_TOP[7:0] : FAST_TOP[7:0];
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      if (div_reg >= div_top) begin
        div_reg <= 8'h00;
        tick_reg <= 1'b1; // see RL14
      end else begin
        div_reg <= div_reg + 8'h01;
      end
    end
  end
  // Two-stage synchronisers; edges only taken from the second stage
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gate_s1_reg <= 2'h0;
      gate_s2_reg <= 2'h0;
      gate_d_reg <= 2'h0;
      ev_s1_reg <= 2'h0;
      ev_s2_reg <= 2'h0;
      ev_d_reg <= 2'h0;
    end else begin
      gate_s1_reg <= gate_pin;
      gate_s2_reg <= gate_s1_reg;
      gate_d_reg <= gate_s2_reg;
      ev_s1_reg <= event_pin;
      ev_s2_reg <= ev_s1_reg;
      ev_d_reg <= ev_s2_reg;
    end
  end
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : chan
      if (g < 2) begin : ext
        // External gates only on the two general counters
        assign gate_lvl_w[g] = gate_s2_reg[g]; // see RL3
        assign gate_rise_w[g] = gate_s2_reg[g] & ~gate_d_reg[g];
        assign tick_w[g] = ctrl_reg[g][`CTRL_EXT_BIT] ?
                           (ev_s2_reg[g] & ~ev_d_reg[g]) : tick_reg; // see RL12
      end else begin : baud
        // Baud counter runs free from the reference; it has no gate pin
        assign gate_lvl_w[g] = 1'b1; // see RL2
        assign gate_rise_w[g] = 1'b0;
        assign tick_w[g] = tick_reg;
      end
      pit_counter u_cnt (
        .clk_sys(clk_sys),
        .rst(rst),
        .mode(ctrl_reg[g][`CTRL_MODE_MSB:`CTRL_MODE_LSB]),
        .bcd(ctrl_reg[g][`CTRL_BCD_BIT]), // see RL1
        .load_val(load_reg[g]),
        .load_stb(load_stb_reg[g]),
        .sw_trig(sw_trig_reg[g]),
        .tick(tick_w[g]),
        .gate_lvl(gate_lvl_w[g]),
        .gate_rise(gate_rise_w[g]),
        .count_reg(count_w[g]),
        .out_reg(out_w[g]),
        .tc_pulse(tc_w[g])
      ); // see RL13
    end
  endgenerate
  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (paddr)
      `OFF_CTRL0: rd_mux = {27'h0, ctrl_reg[0]};
      `OFF_CTRL1: rd_mux = {27'h0, ctrl_reg[1]};
      `OFF_CTRL2: rd_mux = {27'h0, ctrl_reg[2]};
      `OFF_LOAD0: rd_mux = {16'h0000, load_reg[0]};
      `OFF_LOAD1: rd_mux = {16'h0000, load_reg[1]};
      `OFF_LOAD2: rd_mux = {16'h0000, load_reg[2]};
      `OFF_COUNT0: rd_mux = {16'h0000, count_w[0]}; // see RL5
      `OFF_COUNT1: rd_mux = {16'h0000, count_w[1]}; // see RL5
      `OFF_COUNT2: rd_mux = {16'h0000, count_w[2]}; // see RL5
      `OFF_REFSEL: rd_mux = {31'h0, refsel_reg};
      `OFF_SWTRIG: rd_mux = 32'h00000000;
      `OFF_STATUS: rd_mux = {29'h0, status_reg};
      `OFF_MASK: rd_mux = {29'h0, mask_reg};
      default: rd_hit = 1'b0;
    endcase
  end
  // Set beats clear: a terminal count in the clearing cycle survives
  always @* begin
    status_next = status_reg;
    if (wr_en && paddr == `OFF_STATUS) begin
      status_next = status_reg & ~pwdata[2:0];
    end
    status_next = status_next | tc_w; // see RL6 RL12
  end
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (k = 0; k < 3; k = k + 1) begin
        ctrl_reg[k] <= `CTRL_RESET;
        load_reg[k] <= `LOAD_RESET;
      end
      load_stb_reg <= 3'h0;
      sw_trig_reg <= 3'h0;
      refsel_reg <= 1'b0;
      status_reg <= 3'h0;
      mask_reg <= 3'h0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      load_stb_reg <= 3'h0;
      sw_trig_reg <= 3'h0;
      status_reg <= status_next;
      pready <= 1'b0;
      pslverr <= 1'b0;
      // One wait state: answer lands on the second access cycle
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        pslverr <= ~rd_hit;
        prdata <= rd_en ? rd_mux : 32'h00000000;
        if (wr_en) begin
          case (paddr)
            `OFF_CTRL0: ctrl_reg[0] <= pwdata[4:0]; // see RL4
            `OFF_CTRL1: ctrl_reg[1] <= pwdata[4:0]; // see RL4
            `OFF_CTRL2: ctrl_reg[2] <= pwdata[4:0]; // see RL4
            `OFF_LOAD0: begin
              load_reg[0] <= pwdata[15:0];
              load_stb_reg[0] <= 1'b1; // see RL10
            end
            `OFF_LOAD1: begin
              load_reg[1] <= pwdata[15:0];
              load_stb_reg[1] <= 1'b1; // see RL10
            end
            `OFF_LOAD2: begin
              load_reg[2] <= pwdata[15:0]; // see RL15
              load_stb_reg[2] <= 1'b1;
            end
            `OFF_REFSEL: refsel_reg <= pwdata[0]; // see RL14
            `OFF_SWTRIG: sw_trig_reg <= pwdata[2:0]; // see RL7
            `OFF_MASK: mask_reg <= pwdata[2:0];
            default: pslverr <= ~rd_hit;
          endcase
        end
      end
    end
  end
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timer_out <= 2'h3;
      baud_clk <= 1'b1;
      irq <= 1'b0;
    end else begin
      timer_out <= out_w[1:0]; // see RL3
      baud_clk <= out_w[2]; // see RL2
      irq <= |(status_next & mask_reg); // see RL6
    end
  end
endmodule // pit_top

// ---- verification/pit_top_asserts.sv ----
/* APB timing and interrupt checks for the interval timer.
 Assumes it is bound to pit_top and sees only its ports. */
`timescale 1ns/10ps
module pit_top_asserts (
  input wire clk_sys,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Writes land in the first access cycle, before pready shows
  wire wdone = psel && penable && pwrite;
  sequence setup_s; psel && !penable; endsequence
  sequence wait_s; !pready ##1 pready; endsequence
  chk_one_wait: assert property (setup_s |=> wait_s)
    else $error("pready not in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  chk_ready_late: assert property (pready |-> $past(penable))
    else $error("pready without wait state");
  chk_idle_quiet: assert property (!psel |=> !pready)
    else $error("pready without select");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_err_rdata: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  // Interrupt can only drop after software clears status or mask
  chk_irq_drop: assert property ($fell(irq) |->
    $past(wdone) || $past(wdone, 2) || $past(wdone, 3))
    else $error("irq fell without a write");
endmodule // pit_top_asserts

// ---- verification/pit_line_model.sv ----
/* Far-side model: gate levels and an external event stream.
 Assumes the bench requests gates and events at clock edges. */
`timescale 1ns/10ps
module pit_line_model (
  input wire clk_sys,
  input wire rst,
  input wire [1:0] gate_req,
  input wire ev_on,
  output logic [1:0] gate_pin,
  output logic [1:0] event_pin
);
  logic [3:0] ph;
  // Slow edges so the pin synchroniser never misses one
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ph <= 4'h0;
      gate_pin <= 2'h0;
      event_pin <= 2'h0;
    end else begin
      ph <= ph + 4'h1;
      gate_pin <= gate_req;
      if (ev_on && ph == 4'hf) event_pin <= ~event_pin;
    end
  end
endmodule // pit_line_model

// ---- verification/tb_pit_top.sv ----
/* Self-checking bench: APB registers, interrupt flow, waveforms.
 Assumes pit_line_model drives the gate and event pins. */
`timescale 1ns/10ps
`include "pit_consts.vh"
module tb_pit_top;
  logic clk_sys = 0;
  logic rst = 1;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, r;
  logic e;
  logic [1:0] gate_req = 2'h0;
  logic ev_on = 0;
  logic [4:0] cv [3];
  wire [31:0] prdata;
  wire pready, pslverr, baud_clk, irq;
  wire [1:0] gate_pin, event_pin, timer_out;
  int bad_count = 0, compares = 0, cyc = 0, n, hi, lo, dv, ix, md;
  always #20 clk_sys = ~clk_sys;
  pit_top pit_top_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gate_pin(gate_pin), .event_pin(event_pin), .timer_out(timer_out),
    .baud_clk(baud_clk), .irq(irq));
  pit_line_model pit_line_model_inst (.clk_sys(clk_sys), .rst(rst),
    .gate_req(gate_req), .ev_on(ev_on), .gate_pin(gate_pin),
    .event_pin(event_pin));
  task summarize;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask
  function logic sig(input int i);
    return i == 2 ? baud_clk : timer_out[i[0]];
  endfunction
  // Widths of one high and one low phase, in system clocks
  task wave(input int i);
    hi = 0;
    lo = 0;
    while (sig(i) !== 1'b0) @(posedge clk_sys);
    while (sig(i) !== 1'b1) @(posedge clk_sys);
    while (sig(i) !== 1'b0) begin @(posedge clk_sys); hi++; end
    while (sig(i) !== 1'b1) begin @(posedge clk_sys); lo++; end
  endtask
  // Cycles until timer 0 falls, then how long it stays low
  task pulse;
    hi = 0;
    lo = 0;
    while (timer_out[0] !== 1'b0 && hi < 3000) begin @(posedge clk_sys); hi++; end
    while (timer_out[0] !== 1'b1 && lo < 3000) begin @(posedge clk_sys); lo++; end
  endtask
  task wait_irq;
    for (int k = 0; k < 2000 && irq !== 1'b1; k++) @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 40000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'h85654b50));
    repeat (6) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    chk(32'({baud_clk, timer_out}), 32'h7);
    apb(0, `OFF_CTRL1, 32'h0);
    chk(r, 32'(`CTRL_RESET));
    apb(0, `OFF_LOAD2, 32'h0);
    chk(r, 32'(`LOAD_RESET));
    apb(1, 12'h0fc, 32'hffffffff);
    chk(32'(e), 32'h1);
    apb(0, 12'h0fc, 32'h0);
    chk(32'(e), 32'h1);
    chk(r, 32'h0);
    $display("test reset and refusal done");
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 3; j++) begin
        cv[j] = {j < 2 ? 1'($urandom) : 1'b0, 1'($urandom),
          3'($urandom % 7)};
        apb(1, `OFF_CTRL0 + 12'(j * 4), 32'(cv[j]));
      end
      for (int j = 0; j < 3; j++) begin
        apb(0, `OFF_CTRL0 + 12'(j * 4), 32'h0);
        chk(r, 32'(cv[j]));
      end
    end
    $display("test independent setup done");
    gate_req <= 2'h3;
    apb(1, `OFF_MASK, 32'h0);
    apb(1, `OFF_CTRL0, 32'(`MODE_TC_IRQ));
    apb(1, `OFF_STATUS, 32'h7);
    n = 40 + $urandom % 20;
    apb(1, `OFF_LOAD0, n);
    repeat (30) @(posedge clk_sys);
    apb(0, `OFF_COUNT0, 32'h0);
    hi = r;
    repeat (30) @(posedge clk_sys);
    apb(0, `OFF_COUNT0, 32'h0);
    chk(32'(hi < n && r < hi), 32'h1);
    apb(1, `OFF_MASK, 32'h1);
    chk(32'(irq), 32'h0);
    wait_irq();
    chk(32'(irq), 32'h1);
    apb(0, `OFF_STATUS, 32'h0);
    chk(r & 32'h1, 32'h1);
    apb(1, `OFF_MASK, 32'h0);
    chk(32'(irq), 32'h0);
    apb(1, `OFF_MASK, 32'h1);
    chk(32'(irq), 32'h1);
    apb(1, `OFF_STATUS, 32'h1);
    chk(32'(irq), 32'h0);
    $display("test terminal count interrupt done");
    for (int k = 0; k < 4; k++) begin
      md = k[0] ? `MODE_SQUARE : `MODE_RATE;
      ix = k == 2 ? 2 : 1;
      n = 4 + 2 * ($urandom % 4);
      dv = k == 3 ? `REF_SLOW_DIV : `REF_FAST_DIV;
      apb(1, `OFF_REFSEL, 32'(k == 3));
      apb(1, `OFF_CTRL0 + 12'(ix * 4), 32'(md));
      apb(1, `OFF_LOAD0 + 12'(ix * 4), n);
      wave(ix);
      chk(hi + lo, n * dv);
      chk(lo, k[0] ? n * dv / 2 : dv);
    end
    apb(1, `OFF_REFSEL, 32'h0);
    $display("test waveforms done");
    dv = `REF_FAST_DIV;
    gate_req <= 2'h2;
    for (int k = 0; k < 3; k++) begin
      n = 3 + $urandom % 5;
      md = k == 0 ? `MODE_SW_STROBE : k == 1 ? `MODE_ONE_SHOT : `MODE_HW_STROBE;
      apb(1, `OFF_CTRL0, 32'(md));
      apb(1, `OFF_LOAD0, n);
      if (k == 1) apb(1, `OFF_SWTRIG, 32'h1);
      if (k == 2) gate_req <= 2'h3;
      pulse();
      if (k == 1) chk(32'(lo > (n - 1) * dv && lo <= n * dv + 2), 32'h1);
      else begin
        chk(32'(hi > (n - 1) * dv && hi <= n * dv + 8), 32'h1);
        chk(lo, dv);
      end
    end
    gate_req <= 2'h3;
    $display("test strobes and one-shot done");
    apb(1, `OFF_CTRL2, 32'h8);
    apb(1, `OFF_LOAD2, 32'h100);
    repeat (300) @(posedge clk_sys);
    apb(0, `OFF_COUNT2, 32'h0);
    chk(32'(r[7:4] <= 9 && r[3:0] <= 9 && r[15:8] == 0), 32'h1);
    apb(1, `OFF_CTRL0, 32'h16);
    apb(1, `OFF_LOAD0, 32'h5);
    apb(1, `OFF_STATUS, 32'h7);
    repeat (200) @(posedge clk_sys);
    chk(32'(irq), 32'h0);
    ev_on <= 1;
    wait_irq();
    chk(32'(irq), 32'h1);
    ev_on <= 0;
    $display("test bcd and event count done");
    summarize();
  end
endmodule // tb_pit_top
bind pit_top pit_top_asserts pit_top_asserts_inst (.clk_sys(clk_sys),
  .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
